// *** hdl/pmsi_pkg.sv ***
// Purpose: shared constants and types of the host bus unit
// Assumes: one 25 MHz clock, synchronous active-high reset
// Notes: command codes are the bus's own encodings
`default_nettype none
package pmsi_pkg;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] CMD_CFG_RD = 4'hA;
  localparam logic [3:0] CMD_CFG_WR = 4'hB;
  localparam logic [3:0] CMD_MEM_RDM = 4'hC;
  localparam logic [3:0] CMD_MEM_RDL = 4'hE;
  localparam logic [3:0] CMD_MEM_WI = 4'hF;
  // lowest compared address bit: 27 bits for direct io, 16 for rom
  localparam int DIO_CMP_LSB = 5;
  localparam int ROM_CMP_LSB = 16;
  // configuration dword that belongs to the eeprom port
  localparam logic [5:0] EE_CFG_DW = 6'h10;
  // counter value at which an unclaimed access ends in master abort, on the sixth clock after the address phase
  localparam logic [2:0] MABORT_LAST = 3'h5;
  typedef enum logic [2:0] {
    T_IDLE, T_DEC, T_WAIT, T_XFER, T_STOP, T_TURN
  } pmsi_tst_t;
  typedef enum logic [2:0] {
    M_IDLE, M_REQ, M_ADDR, M_DATA, M_TURN
  } pmsi_mst_t;
  typedef enum logic [1:0] {RT_CFG, RT_SIF, RT_ROM, RT_EIF} pmsi_route_t;
endpackage
`default_nettype wire

// *** hdl/pmsi_host_bus_unit.sv ***
// Purpose: host bus unit, bus master and target of the bridge
// Assumes: bus pins are synchronous to clk, which is the bus clock
// Notes: one data phase per access; pins split into value and enable
//
// What this block does
// [RQ1] phase ends when both ready lines asserted
// [RQ2] master ready only with valid write data
// [RQ3] target ready only with valid read data
// [RQ4] bus pins sampled on rising clk, frame also drives stop directly
// [RQ5] processor bus clock derived from bus clock
// [RQ6] parity error reported two clocks after data
// [RQ7] parity error only after claim and phase
// [RQ8] request arbiter, wait for own grant
// [RQ9] bus reset also resets communications processor
// [RQ10] host may park lines low in reset
// [RQ11] enabled system error flags address parity
// [RQ12] target stop ends the master's transaction
// [RQ13] eeprom data open-drain, eeprom clock driven
// [RQ14] parity generated and checked on bus data
// [RQ15] limited master commands, broad target commands
// [RQ16] disconnect when initiator wants second phase
// [RQ17] compare upper 27 or 16 address bits
// [RQ18] eight dwords direct io, 64k rom region
// [RQ19] each register decoded, medium claim timing
// [RQ20] each access routed to one sub-unit
// [RQ21] hold captured address phase, idsel for config
// [RQ22] configuration claimed only with idsel asserted
// [RQ23] no claim ends in master abort
// [RQ24] no request and released pins during reset
`default_nettype none
module pmsi_host_bus_unit
  import pmsi_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] pci_ad,
  output logic [31:0] pci_ad_val,
  output logic pci_ad_oe,
  input wire logic [3:0] pci_cbe_n,
  output logic [3:0] pci_cbe_n_val,
  output logic pci_cbe_n_oe,
  input wire logic pci_par,
  output logic pci_par_val,
  output logic pci_par_oe,
  input wire logic pci_frame_n,
  output logic pci_frame_n_val,
  output logic pci_frame_n_oe,
  input wire logic pci_irdy_n,
  output logic pci_irdy_n_val,
  output logic pci_irdy_n_oe,
  input wire logic pci_trdy_n,
  output logic pci_trdy_n_val,
  output logic pci_trdy_n_oe,
  input wire logic pci_devsel_n,
  output logic pci_devsel_n_val,
  output logic pci_devsel_n_oe,
  input wire logic pci_stop_n,
  output logic pci_stop_n_val,
  output logic pci_stop_n_oe,
  input wire logic pci_perr_n,
  output logic pci_perr_n_val,
  output logic pci_perr_n_oe,
  output logic pci_serr_n_val,
  output logic pci_serr_n_oe,
  output logic pci_req_n,
  input wire logic pci_gnt_n,
  input wire logic pci_idsel,
  input wire logic io_en,
  input wire logic mem_en,
  input wire logic rom_en,
  input wire logic bm_en,
  input wire logic perr_en,
  input wire logic serr_en,
  input wire logic [31:DIO_CMP_LSB] dio_io_base,
  input wire logic [31:DIO_CMP_LSB] dio_mem_base,
  input wire logic [31:ROM_CMP_LSB] rom_base,
  output logic tgt_req,
  output logic tgt_write,
  output pmsi_route_t tgt_route,
  output logic [31:0] tgt_addr,
  output logic [3:0] tgt_be,
  output logic [31:0] tgt_wdata,
  input wire logic [31:0] tgt_rdata,
  input wire logic tgt_ack,
  input wire logic mst_start,
  input wire logic mst_write,
  input wire logic mst_inval,
  input wire logic [31:0] mst_addr,
  input wire logic [31:0] mst_wdata,
  input wire logic [3:0] mst_be,
  output logic mst_busy,
  output logic mst_done,
  output logic mst_abort,
  output logic mst_stopped,
  output logic mst_locked,
  output logic [31:0] mst_rdata,
  output logic par_err,
  output logic processor_bus_clock,
  output logic commproc_reset,
  input wire logic ee_clk_drive,
  input wire logic ee_data_low,
  output logic ee_data,
  output logic eeprom_serial_clock,
  input wire logic eeprom_serial_data,
  output logic eeprom_serial_data_val,
  output logic eeprom_serial_data_oe
);
  typedef struct packed {
    pmsi_tst_t tst;
    pmsi_mst_t mst;
    logic frm_q;
    logic [31:0] addr;
    logic [3:0] cmd;
    logic idsel;
    pmsi_route_t route;
    logic [3:0] be;
    logic [31:0] wdata;
    logic req;
    logic [31:0] ad_o;
    logic ad_oe;
    logic [3:0] cbe_o;
    logic cbe_oe;
    logic par_o;
    logic par_oe;
    logic chk_addr;
    logic par_exp_a;
    logic chk_data;
    logic chk_mst;
    logic par_exp_d;
    logic perr_act;
    logic perr_tail;
    logic serr_act;
    logic lock;
    logic [2:0] cnt;
    logic m_write;
    logic [31:0] m_addr;
    logic [31:0] m_wdata;
    logic [3:0] m_be;
    logic [31:0] rdata;
    logic done;
    logic abort;
    logic stopped;
    logic pbclk;
    logic cp_rst;
    logic ee_s1;
    logic ee_s2;
    logic ee_clk;
    logic ee_low;
  } pmsi_state_t;

  pmsi_state_t st_ff;
  pmsi_state_t nxt_st;
  logic hit;
  pmsi_route_t route;
  logic dphase_done;

  // parity covers the data lines and the command/byte-enable lines
  function automatic logic bus_parity(input logic [31:0] d,
                                      input logic [3:0] c);
    return ^{d, c};
  endfunction

  function automatic logic is_mem_cmd(input logic [3:0] c);
    return c == CMD_MEM_RD || c == CMD_MEM_WR || c == CMD_MEM_RDM ||
           c == CMD_MEM_RDL || c == CMD_MEM_WI;
  endfunction

  // [RQ17] [RQ18] upper-bit compares set window sizes
  // [RQ22] configuration claimed only with idsel
  always_comb begin
    logic cfg;
    logic io_hit;
    logic dio_mem;
    logic rom_mem;
    cfg = (st_ff.cmd == CMD_CFG_RD || st_ff.cmd == CMD_CFG_WR) &&
          st_ff.idsel && st_ff.addr[1:0] == 2'b00;
    io_hit = (st_ff.cmd == CMD_IO_RD || st_ff.cmd == CMD_IO_WR) && io_en &&
             st_ff.addr[31:DIO_CMP_LSB] == dio_io_base;
    dio_mem = is_mem_cmd(st_ff.cmd) && mem_en &&
              st_ff.addr[31:DIO_CMP_LSB] == dio_mem_base;
    rom_mem = is_mem_cmd(st_ff.cmd) && rom_en &&
              st_ff.addr[31:ROM_CMP_LSB] == rom_base;
    hit = cfg || io_hit || dio_mem || rom_mem;
    // [RQ20] exactly one sub-unit per access
    if (cfg) begin
      route = (st_ff.addr[7:2] == EE_CFG_DW) ? RT_EIF : RT_CFG;
    end else if (io_hit || dio_mem) begin
      route = RT_SIF;
    end else begin
      route = RT_ROM;
    end
  end

  // [RQ1] completion needs both ready lines
  assign dphase_done = st_ff.tst == T_XFER && !pci_irdy_n;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.frm_q = pci_frame_n;
    nxt_st.req = 1'b0;
    nxt_st.done = 1'b0;
    nxt_st.abort = 1'b0;
    nxt_st.stopped = 1'b0;
    nxt_st.chk_addr = 1'b0;
    nxt_st.chk_data = 1'b0;
    nxt_st.perr_act = 1'b0;
    nxt_st.serr_act = 1'b0;
    nxt_st.perr_tail = st_ff.perr_act;
    // [RQ5] processor bus clock is the bus clock halved
    nxt_st.pbclk = ~st_ff.pbclk;
    nxt_st.cp_rst = 1'b0;
    nxt_st.ee_s1 = eeprom_serial_data;
    nxt_st.ee_s2 = st_ff.ee_s1;
    nxt_st.ee_clk = ee_clk_drive;
    nxt_st.ee_low = ee_data_low;
    // [RQ14] parity one clock behind the lines it covers
    nxt_st.par_oe = st_ff.ad_oe;
    nxt_st.par_o = bus_parity(st_ff.ad_o,
                              st_ff.cbe_oe ? st_ff.cbe_o : pci_cbe_n);
    // [RQ11] address parity checked whether claimed or not
    if (st_ff.chk_addr && pci_par != st_ff.par_exp_a && serr_en) begin
      nxt_st.serr_act = 1'b1;
    end
    // [RQ6] [RQ14] data parity checked clock after data
    if (st_ff.chk_data && pci_par != st_ff.par_exp_d && perr_en) begin
      nxt_st.perr_act = 1'b1;
      nxt_st.lock = st_ff.lock | st_ff.chk_mst;
    end

    case (st_ff.tst)
      T_IDLE: begin
        // [RQ4] [RQ21] address phase captured and held
        if (st_ff.frm_q && !pci_frame_n && st_ff.mst != M_ADDR) begin
          nxt_st.addr = pci_ad;
          nxt_st.cmd = pci_cbe_n;
          nxt_st.idsel = pci_idsel;
          nxt_st.par_exp_a = bus_parity(pci_ad, pci_cbe_n);
          nxt_st.chk_addr = 1'b1;
          nxt_st.tst = T_DEC;
        end
      end
      T_DEC: begin
        // [RQ19] [RQ15] claim in second clock, medium timing
        if (hit) begin
          nxt_st.route = route;
          nxt_st.req = !st_ff.cmd[0];
          nxt_st.tst = T_WAIT;
        end else begin
          nxt_st.tst = T_IDLE;
        end
      end
      T_WAIT: begin
        // [RQ3] read data on the lines with target ready
        if (st_ff.cmd[0]) begin
          nxt_st.tst = T_XFER;
        end else if (tgt_ack) begin
          nxt_st.ad_o = tgt_rdata;
          nxt_st.ad_oe = 1'b1;
          nxt_st.tst = T_XFER;
        end
      end
      T_XFER: begin
        if (dphase_done) begin
          nxt_st.be = pci_cbe_n;
          if (st_ff.cmd[0]) begin
            nxt_st.wdata = pci_ad;
            nxt_st.req = 1'b1;
            nxt_st.chk_data = 1'b1;
            nxt_st.chk_mst = 1'b0;
            nxt_st.par_exp_d = bus_parity(pci_ad, pci_cbe_n);
          end
          nxt_st.tst = pci_frame_n ? T_TURN : T_STOP;
        end
      end
      T_STOP: begin
        if (pci_frame_n) begin
          nxt_st.tst = T_TURN;
        end
      end
      T_TURN: begin
        nxt_st.ad_oe = 1'b0;
        nxt_st.tst = T_IDLE;
      end
      default: nxt_st.tst = T_IDLE;
    endcase

    case (st_ff.mst)
      M_IDLE: begin
        // parity fault on master read data blocks further mastering until reset
        if (mst_start && bm_en && !st_ff.lock) begin
          nxt_st.m_write = mst_write;
          nxt_st.m_addr = mst_addr;
          nxt_st.m_wdata = mst_wdata;
          nxt_st.m_be = mst_be;
          // [RQ15] only read line, write, write-and-invalidate
          nxt_st.cmd = !mst_write ? CMD_MEM_RDL :
                       mst_inval ? CMD_MEM_WI : CMD_MEM_WR;
          nxt_st.mst = M_REQ;
        end
      end
      M_REQ: begin
        // [RQ8] start only on own grant with the bus idle
        if (!pci_gnt_n && pci_frame_n && pci_irdy_n &&
            st_ff.tst == T_IDLE) begin
          nxt_st.ad_o = st_ff.m_addr;
          nxt_st.ad_oe = 1'b1;
          nxt_st.cbe_o = st_ff.cmd;
          nxt_st.cbe_oe = 1'b1;
          nxt_st.cnt = 3'h0;
          nxt_st.mst = M_ADDR;
        end
      end
      M_ADDR: begin
        // [RQ2] write data placed together with initiator ready
        nxt_st.ad_o = st_ff.m_wdata;
        nxt_st.ad_oe = st_ff.m_write;
        nxt_st.cbe_o = st_ff.m_be;
        nxt_st.mst = M_DATA;
      end
      M_DATA: begin
        if (st_ff.cnt != MABORT_LAST) begin
          nxt_st.cnt = st_ff.cnt + 3'h1;
        end
        // [RQ1] [RQ12] [RQ23] completion, stop or abort
        if (!pci_trdy_n && !pci_devsel_n) begin
          nxt_st.rdata = pci_ad;
          nxt_st.chk_data = !st_ff.m_write;
          nxt_st.chk_mst = 1'b1;
          nxt_st.par_exp_d = bus_parity(pci_ad, st_ff.cbe_o);
          nxt_st.done = 1'b1;
          nxt_st.mst = M_TURN;
        end else if (!pci_stop_n && !pci_devsel_n) begin
          nxt_st.stopped = 1'b1;
          nxt_st.mst = M_TURN;
        end else if (pci_devsel_n && st_ff.cnt == MABORT_LAST) begin
          nxt_st.abort = 1'b1;
          nxt_st.mst = M_TURN;
        end
      end
      M_TURN: begin
        nxt_st.ad_oe = 1'b0;
        nxt_st.cbe_oe = 1'b0;
        nxt_st.mst = M_IDLE;
      end
      default: nxt_st.mst = M_IDLE;
    endcase

    // [RQ9] [RQ24] reset clears all but frm_q and holds processor in reset
    if (sys_rst) begin
      nxt_st = '0;
      nxt_st.frm_q = 1'b1;
      nxt_st.cp_rst = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    st_ff <= nxt_st;
  end

  assign pci_ad_val = st_ff.ad_o;
  assign pci_ad_oe = st_ff.ad_oe;
  assign pci_cbe_n_val = st_ff.cbe_o;
  assign pci_cbe_n_oe = st_ff.cbe_oe;
  assign pci_par_val = st_ff.par_o;
  assign pci_par_oe = st_ff.par_oe;
  assign pci_frame_n_oe = st_ff.mst inside {M_ADDR, M_DATA, M_TURN};
  assign pci_frame_n_val = st_ff.mst != M_ADDR;
  assign pci_irdy_n_oe = st_ff.mst inside {M_DATA, M_TURN};
  assign pci_irdy_n_val = st_ff.mst != M_DATA;
  assign pci_devsel_n_oe = st_ff.tst inside {T_WAIT, T_XFER, T_STOP, T_TURN};
  assign pci_devsel_n_val = st_ff.tst == T_TURN;
  assign pci_trdy_n_oe = pci_devsel_n_oe;
  assign pci_trdy_n_val = st_ff.tst != T_XFER;
  assign pci_stop_n_oe = pci_devsel_n_oe;
  // [RQ16] disconnect while initiator holds frame
  assign pci_stop_n_val = !((st_ff.tst == T_XFER && !pci_frame_n) ||
                            st_ff.tst == T_STOP);
  // [RQ7] perr only follows a claimed, completed phase
  assign pci_perr_n_val = !st_ff.perr_act;
  assign pci_perr_n_oe = st_ff.perr_act | st_ff.perr_tail;
  assign pci_serr_n_val = 1'b0;
  assign pci_serr_n_oe = st_ff.serr_act;
  assign pci_req_n = st_ff.mst != M_REQ;
  assign tgt_req = st_ff.req;
  assign tgt_write = st_ff.cmd[0];
  assign tgt_route = st_ff.route;
  assign tgt_addr = st_ff.addr;
  assign tgt_be = st_ff.be;
  assign tgt_wdata = st_ff.wdata;
  assign mst_busy = st_ff.mst != M_IDLE;
  assign mst_done = st_ff.done;
  assign mst_abort = st_ff.abort;
  assign mst_stopped = st_ff.stopped;
  assign mst_locked = st_ff.lock;
  assign mst_rdata = st_ff.rdata;
  assign par_err = st_ff.perr_act | st_ff.serr_act;
  assign processor_bus_clock = st_ff.pbclk;
  assign commproc_reset = st_ff.cp_rst;
  // [RQ13] open-drain data, driven clock
  assign eeprom_serial_clock = st_ff.ee_clk;
  assign eeprom_serial_data_val = 1'b0;
  assign eeprom_serial_data_oe = st_ff.ee_low;
  assign ee_data = st_ff.ee_s2;

  chk_devsel_medium: assert property (@(posedge clk) disable iff (sys_rst) // [RQ19]
    $rose(pci_devsel_n_oe) |-> $past(st_ff.tst) == T_DEC &&
    $past(pci_frame_n, 2) == 1'b0)
    else $error("claim not in medium decode slot");
  chk_trdy_rdata: assert property (@(posedge clk) disable iff (sys_rst) // [RQ3]
    (!pci_trdy_n_val && pci_trdy_n_oe && !st_ff.cmd[0]) |-> pci_ad_oe)
    else $error("target ready without read data");
  chk_irdy_wdata: assert property (@(posedge clk) disable iff (sys_rst) // [RQ2]
    (!pci_irdy_n_val && pci_irdy_n_oe && st_ff.m_write) |->
    pci_ad_oe && pci_ad_val == st_ff.m_wdata)
    else $error("initiator ready without write data");
  chk_perr_delay: assert property (@(posedge clk) disable iff (sys_rst) // [RQ6]
    $rose(st_ff.perr_act) |-> $past(st_ff.chk_data) &&
    $past(pci_par) != $past(st_ff.par_exp_d))
    else $error("parity report not two clocks after data");
  chk_perr_claim: assert property (@(posedge clk) disable iff (sys_rst) // [RQ7]
    (st_ff.perr_act && !st_ff.chk_mst) |-> $past(dphase_done, 2))
    else $error("parity report without claimed phase");
  chk_req_reset: assert property (@(posedge clk) // [RQ24]
    $past(sys_rst) |-> pci_req_n && !pci_ad_oe && !pci_frame_n_oe)
    else $error("bus not released after reset");
  chk_frame_grant: assert property (@(posedge clk) disable iff (sys_rst) // [RQ8]
    $rose(pci_frame_n_oe) |-> $past(!pci_gnt_n) && $past(!pci_req_n))
    else $error("frame started without grant");
  chk_stop_multi: assert property (@(posedge clk) disable iff (sys_rst) // [RQ16]
    (st_ff.tst == T_XFER && !pci_frame_n) |-> !pci_stop_n_val)
    else $error("no disconnect on multi-phase access");
  chk_abort_end: assert property (@(posedge clk) disable iff (sys_rst) // [RQ23]
    (st_ff.mst == M_DATA && st_ff.cnt == MABORT_LAST && pci_devsel_n &&
     pci_stop_n && pci_trdy_n) |=> mst_abort && st_ff.mst == M_TURN
    ##1 st_ff.mst == M_IDLE)
    else $error("master abort not taken");
  chk_serr_cause: assert property (@(posedge clk) disable iff (sys_rst) // [RQ11]
    pci_serr_n_oe |-> $past(st_ff.chk_addr) && $past(serr_en))
    else $error("system error without address check");
endmodule
`default_nettype wire

// *** testbench/pmsi_host_model.sv ***
// Purpose: host side model: initiator, arbiter and memory target
// Assumes: released control lines read high through pull-ups
// Notes: mode 0 never claims, 1 claims, 2 claims with retry
`default_nettype none
module pmsi_host_model
  import pmsi_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] ad,
  input wire logic [3:0] cbe_n,
  input wire logic frame_n,
  input wire logic irdy_n,
  input wire logic trdy_n,
  input wire logic devsel_n,
  input wire logic stop_n,
  input wire logic req_n,
  input wire logic dev_master,
  output logic [31:0] h_ad,
  output logic h_ad_oe,
  output logic [3:0] h_cbe_n,
  output logic h_cbe_oe,
  output logic h_par,
  output logic h_par_oe,
  output logic h_frame_n,
  output logic h_irdy_n,
  output logic h_m_oe,
  output logic h_trdy_n,
  output logic h_devsel_n,
  output logic h_stop_n,
  output logic h_t_oe,
  output logic gnt_n
);
  timeunit 1ns;
  timeprecision 1ps;
  int cyc = 0;
  int mode = 1;
  int wait_cyc = 0;
  int done_cyc = 0;
  int addr_cyc = 0;
  bit busy = 0;
  bit par_flip = 0;
  bit flip_q = 0;
  bit oe_q = 0;
  logic [35:0] q = '0;
  logic [31:0] rd_word = '0;
  logic [31:0] seen_addr, seen_data;
  logic [3:0] seen_cmd;

  initial begin
    {h_ad, h_cbe_n, h_par, h_par_oe, gnt_n} = {36'h0, 3'h3};
    {h_frame_n, h_irdy_n, h_trdy_n, h_devsel_n, h_stop_n} = 5'h1F;
    {h_m_oe, h_t_oe} = 2'h0;
    // park lines low only while reset holds
    {h_ad_oe, h_cbe_oe} = 2'h3;
    wait (!sys_rst);
    @(negedge clk);
    {h_ad_oe, h_cbe_oe} = 2'h0;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    q <= {ad, cbe_n};
    oe_q <= h_ad_oe;
    flip_q <= par_flip;
  end

  always @(negedge clk) begin
    // parity trails its data by one clock
    h_par = ^q ^ flip_q;
    h_par_oe = oe_q;
    // grant only while the host stays off the bus
    gnt_n = req_n | busy;
  end

  // one phase held until ready, stop or abort
  task automatic host_cycle(input logic [31:0] a, input logic [3:0] c,
      input logic [31:0] wd, input logic [1:0] bad, input bit burst,
      output logic [31:0] rd, output bit cl, output bit st);
    int n;
    n = 0;
    cl = 0;
    busy = 1;
    @(negedge clk);
    while (!frame_n || !irdy_n || dev_master)
      @(negedge clk);
    {h_ad_oe, h_cbe_oe, h_m_oe, h_frame_n} = 4'hE;
    {h_ad, h_cbe_n, par_flip} = {a, c, bad[0]};
    addr_cyc = cyc;
    @(negedge clk);
    {h_frame_n, h_irdy_n, h_cbe_n, par_flip} = {!burst, 1'b0, 4'h0, bad[1]};
    h_ad = wd;
    h_ad_oe = c[0];
    do begin
      @(posedge clk);
      n++;
      cl |= !devsel_n;
    end while (trdy_n && stop_n && (n < 6 || !devsel_n) && n < 40);
    rd = ad;
    st = !stop_n;
    done_cyc = cyc;
    @(negedge clk);
    {h_frame_n, h_irdy_n, h_ad_oe, par_flip} = 4'hC;
    @(negedge clk);
    {h_m_oe, h_cbe_oe, busy} = 3'h0;
  endtask

  // target side: fast claim, ready after wait_cyc clocks in mode 1, stop with the claim in mode 2
  always begin
    @(posedge clk);
    if (!sys_rst && dev_master && !frame_n && mode != 0) begin
      {seen_addr, seen_cmd} = {ad, cbe_n};
      @(negedge clk);
      {h_t_oe, h_devsel_n, h_stop_n} = {1'b1, 1'b0, mode != 2};
      repeat (wait_cyc) @(negedge clk);
      h_trdy_n = (mode == 2);
      h_ad = rd_word;
      // read data on the lines with target ready
      h_ad_oe = !seen_cmd[0] && mode == 1;
      do @(posedge clk);
      while (irdy_n || (trdy_n && stop_n));
      seen_data = ad;
      @(negedge clk);
      {h_devsel_n, h_trdy_n, h_stop_n, h_ad_oe} = 4'hE;
      @(negedge clk);
      h_t_oe = 0;
    end
  end
endmodule
`default_nettype wire

// *** testbench/testbench.sv ***
// Purpose: self-checking bench of the host bus unit
// Assumes: host model stands for every other agent on the bus
// Notes: inputs change on the falling edge; fixed seed repeats runs
`default_nettype none
module testbench;
  import pmsi_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, sys_rst = 1, flt = 0, pci_gnt_n, pci_idsel = 0;
  logic io_en = 1, mem_en = 1, rom_en = 1, bm_en = 1, perr_en = 1;
  logic serr_en = 1, mst_start = 0, mst_write = 0, mst_inval = 0;
  logic tgt_ack = 0, ee_clk_drive = 0, ee_data_low = 0, ee_mem_low = 0;
  logic [31:DIO_CMP_LSB] dio_io_base, dio_mem_base;
  logic [31:ROM_CMP_LSB] rom_base;
  logic [31:0] tgt_rdata = 0, mst_addr = 0, mst_wdata = 0, last_wd;
  logic [31:0] pci_ad_val, tgt_addr, tgt_wdata, mst_rdata, h_ad;
  logic [3:0] pci_cbe_n_val, tgt_be, h_cbe_n, mst_be = 0;
  logic pci_ad_oe, pci_cbe_n_oe, pci_par_val, pci_par_oe, pci_frame_n_val;
  logic pci_frame_n_oe, pci_irdy_n_val, pci_irdy_n_oe, pci_trdy_n_val;
  logic pci_trdy_n_oe, pci_devsel_n_val, pci_devsel_n_oe, pci_stop_n_val;
  logic pci_stop_n_oe, pci_perr_n_val, pci_perr_n_oe, pci_serr_n_val;
  logic pci_serr_n_oe, pci_req_n, tgt_req, tgt_write, mst_busy, mst_done;
  logic mst_abort, mst_stopped, mst_locked, par_err, processor_bus_clock;
  logic commproc_reset, ee_data, eeprom_serial_clock;
  logic eeprom_serial_data_val, eeprom_serial_data_oe;
  logic h_ad_oe, h_cbe_oe, h_par, h_par_oe, h_frame_n, h_irdy_n, h_m_oe;
  logic h_trdy_n, h_devsel_n, h_stop_n, h_t_oe;
  logic [2:0] got = 0;
  pmsi_route_t tgt_route, last_route;
  int err_count = 0, compares = 0, seed = 97287;
  int n_req = 0, n_perr = 0, n_serr = 0, perr_cyc = 0, serr_cyc = 0;
  // released lines: pull-ups on control, a toggling pattern elsewhere
  wire [31:0] ad = pci_ad_oe ? pci_ad_val : h_ad_oe ? h_ad : {16{flt, !flt}};
  wire [3:0] cbe = pci_cbe_n_oe ? pci_cbe_n_val :
    h_cbe_oe ? h_cbe_n : {2{flt, !flt}};
  wire par = pci_par_oe ? pci_par_val : h_par_oe ? h_par : flt;
  wire frame = pci_frame_n_oe ? pci_frame_n_val : !h_m_oe | h_frame_n;
  wire irdy = pci_irdy_n_oe ? pci_irdy_n_val : !h_m_oe | h_irdy_n;
  wire trdy = pci_trdy_n_oe ? pci_trdy_n_val : !h_t_oe | h_trdy_n;
  wire devsel = pci_devsel_n_oe ? pci_devsel_n_val : !h_t_oe | h_devsel_n;
  wire stop = pci_stop_n_oe ? pci_stop_n_val : !h_t_oe | h_stop_n;
  wire perr = !pci_perr_n_oe | pci_perr_n_val;
  wire edata = !(eeprom_serial_data_oe || ee_mem_low);

  pmsi_host_bus_unit u_dut (.*, .pci_ad(ad), .pci_cbe_n(cbe), .pci_par(par),
    .pci_frame_n(frame), .pci_irdy_n(irdy), .pci_trdy_n(trdy),
    .pci_devsel_n(devsel), .pci_stop_n(stop), .pci_perr_n(perr),
    .eeprom_serial_data(edata));

  pmsi_host_model u_host (.*, .cbe_n(cbe), .frame_n(frame), .irdy_n(irdy),
    .trdy_n(trdy), .devsel_n(devsel), .stop_n(stop), .req_n(pci_req_n),
    .dev_master(pci_frame_n_oe), .gnt_n(pci_gnt_n));

  always #20 clk = ~clk;
  always @(negedge clk) flt <= !flt;

  always @(posedge clk) begin
    got |= {mst_done, mst_abort, mst_stopped};
    if (tgt_req) begin
      n_req++;
      {last_route, last_wd} = {tgt_route, tgt_wdata};
    end
    if (pci_perr_n_oe && !pci_perr_n_val) begin
      n_perr++;
      perr_cyc = u_host.cyc;
    end
    if (pci_serr_n_oe) begin
      n_serr++;
      serr_cyc = u_host.cyc;
    end
  end

  // sub-unit answers two clocks after each request
  always @(negedge clk) begin
    tgt_ack <= 1'b0;
    if (tgt_req) begin
      repeat (2) @(negedge clk);
      tgt_ack <= 1'b1;
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tcyc(input logic [31:0] a, input logic [3:0] c,
      input logic [1:0] bad, input bit burst, input bit hit,
      input pmsi_route_t rt);
    logic [31:0] wd, rd;
    bit cl, st;
    int r0;
    wd = $random(seed);
    tgt_rdata = ~wd;
    r0 = n_req;
    u_host.host_cycle(a, c, wd, bad, burst, rd, cl, st);
    repeat (4) @(negedge clk);
    check(cl, hit);
    if (hit && bad == 2'h0) begin
      check(n_req - r0, 1);
      check(last_route, rt);
      check(tgt_addr, a);
      check(c[0] ? last_wd : rd, c[0] ? wd : ~wd);
      check(st, burst);
    end
  endtask

  task automatic mrun(input bit w, input bit inv, input int md,
      input logic [3:0] cmd);
    logic [2:0] exp;
    exp = (md == 1) ? 3'h4 : (md == 0) ? 3'h2 : 3'h1;
    {u_host.mode, u_host.wait_cyc} = {md, {$random(seed)} % 4};
    {mst_write, mst_inval, u_host.rd_word} = {w, inv, $random(seed)};
    mst_addr = {$random(seed)} & 32'hFFFF_FFFC;
    {mst_wdata, mst_be, got} = {$random(seed), 4'h0, 3'h0};
    mst_start = 1;
    @(negedge clk);
    mst_start = 0;
    for (int n = 0; n < 80 && (mst_busy !== 1'b0 || got == 0); n++)
      @(negedge clk);
    repeat (3) @(negedge clk);
    check(got, exp);
    if (md == 1 && !u_host.par_flip) begin
      check(u_host.seen_cmd, cmd);
      check(u_host.seen_addr, mst_addr);
      check(w ? u_host.seen_data : mst_rdata,
        w ? mst_wdata : u_host.rd_word);
    end
  endtask

  // run needs well under 8000 clocks; this span is ample
  initial begin
    #(40 * 20000);
    err_count++;
    stop_test();
  end

  initial begin
    logic p;
    logic [31:0] off;
    logic [3:0] mc[5];
    mc = '{CMD_MEM_RD, CMD_MEM_WR, CMD_MEM_RDM, CMD_MEM_RDL, CMD_MEM_WI};
    dio_io_base = 27'($random(seed));
    dio_mem_base = {1'b0, 26'($random(seed))};
    rom_base = {1'b1, 15'($random(seed))};
    repeat (6) begin
      @(negedge clk);
      check({pci_req_n, pci_ad_oe, pci_frame_n_oe, pci_devsel_n_oe}, 4'h8);
      check(commproc_reset, 1'b1);
    end
    sys_rst = 0;
    @(negedge clk);
    check(commproc_reset, 1'b0);
    repeat (3) begin
      p = processor_bus_clock;
      @(negedge clk);
      check(processor_bus_clock, !p);
    end
    for (int i = 0; i < 4; i++) begin
      {ee_clk_drive, ee_data_low, ee_mem_low} = {2'(i), i == 2};
      repeat (3) @(negedge clk);
      check({eeprom_serial_clock, eeprom_serial_data_oe, ee_data,
        eeprom_serial_data_val}, {ee_clk_drive, ee_data_low, edata, 1'b0});
    end
    pci_idsel = 1;
    tcyc({24'h0, EE_CFG_DW, 2'h0}, CMD_CFG_WR, 2'h0, 0, 1, RT_EIF);
    tcyc(32'h4, CMD_CFG_RD, 2'h0, 0, 1, RT_CFG);
    pci_idsel = 0;
    tcyc(32'h4, CMD_CFG_RD, 2'h0, 0, 0, RT_CFG);
    for (int i = 0; i < 30; i++) begin
      off = $random(seed);
      case (i % 6)
        0: tcyc({dio_io_base, off[4:0]}, {3'h1, off[5]}, 0, 0, 1, RT_SIF);
        1: tcyc({dio_mem_base, off[4:0]}, mc[i % 5], 0, 0, 1, RT_SIF);
        2: tcyc({rom_base, off[15:0]}, CMD_MEM_RD, 0, 0, 1, RT_ROM);
        3: tcyc({dio_io_base ^ 27'h1, off[4:0]}, CMD_IO_WR, 0, 0, 0, RT_SIF);
        4: tcyc({rom_base ^ 16'h1, off[15:0]}, CMD_MEM_RD, 0, 0, 0, RT_ROM);
        default: tcyc({dio_mem_base, 5'h1C}, CMD_MEM_WR, 0, 1, 1, RT_SIF);
      endcase
    end
    n_perr = 0;
    tcyc({dio_mem_base, 5'h4}, CMD_MEM_WR, 2'h2, 0, 1, RT_SIF);
    check(n_perr, 1);
    check(perr_cyc - u_host.done_cyc, 2);
    tcyc({dio_io_base ^ 27'h1, 5'h0}, CMD_IO_WR, 2'h2, 0, 0, RT_SIF);
    check(n_perr, 1);
    n_serr = 0;
    tcyc({dio_io_base ^ 27'h2, 5'h0}, CMD_IO_WR, 2'h1, 0, 0, RT_SIF);
    check(serr_cyc - u_host.addr_cyc, 2);
    serr_en = 0;
    tcyc({dio_io_base ^ 27'h2, 5'h0}, CMD_IO_WR, 2'h1, 0, 0, RT_SIF);
    check(n_serr, 1);
    mrun(0, 0, 1, CMD_MEM_RDL);
    mrun(1, 0, 1, CMD_MEM_WR);
    mrun(1, 1, 1, CMD_MEM_WI);
    mrun(1, 0, 0, CMD_MEM_WR);
    mrun(1, 0, 2, CMD_MEM_WR);
    u_host.par_flip = 1;
    mrun(0, 0, 1, CMD_MEM_RDL);
    u_host.par_flip = 0;
    check(mst_locked, 1'b1);
    mst_start = 1;
    @(negedge clk);
    mst_start = 0;
    repeat (4) @(negedge clk);
    check(pci_req_n, 1'b1);
    sys_rst = 1;
    repeat (6) @(negedge clk);
    check({commproc_reset, pci_req_n, mst_locked}, 3'h6);
    sys_rst = 0;
    @(negedge clk);
    mrun(1, 0, 1, CMD_MEM_WR);
    stop_test();
  end
endmodule
`default_nettype wire
